/* hdl/pbpp_pkg.sv */
// Shared constants and types for the processor bus peripheral port.
// Assumes a single 125 MHz clock; bus phases are one-cycle enable pulses.
package pbpp_pkg;
  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int STAT_W = 8;
  // ==========================================================
  // Status word bit positions
  localparam int ST_INTA = 0;
  localparam int ST_WO_N = 1;
  localparam int ST_STACK = 2;
  localparam int ST_HLTA = 3;
  localparam int ST_OUT = 4;
  localparam int ST_M1 = 5;
  localparam int ST_INP = 6;
  localparam int ST_MEMR = 7;
  // ==========================================================
  // Reset values and timing counts
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 8'h00;
  localparam int PHASE_DIV = 4;
  localparam int WAIT_CYCLES = 2;
  // ==========================================================
  // Bus styles and host states
  typedef enum logic [0:0] {
    PBPP_SHARED = 1'b0,
    PBPP_STATUS = 1'b1
  } pbpp_style_t;
  typedef enum logic [2:0] {
    PBPP_IDLE = 3'b000,
    PBPP_STAT = 3'b001,
    PBPP_ADDR = 3'b010,
    PBPP_STRB = 3'b011,
    PBPP_WAIT = 3'b100,
    PBPP_DONE = 3'b101
  } pbpp_state_t;
endpackage

/* hdl/pbpp_if.sv */
// Interface joining the peripheral and the processor-side bus end.
// Assumes the bench resolves the shared data bus from the enables.
`timescale 1ns/1ns
`default_nettype none
interface pbpp_if;
  import pbpp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dataHost;
  logic dataHostOe;
  logic [DATA_W-1:0] dataPeri;
  logic dataPeriOe;
  logic readWrite;
  logic valid_address_qualifier;
  logic data_bus_drive_enable;
  logic data_in_strobe;
  logic writeStrobe;
  logic cycleStatusStrobe;
  logic phase1;
  logic phase2;
  logic ready;
  modport peri (input addr, dataHost, dataHostOe, readWrite, valid_address_qualifier,
    data_bus_drive_enable, data_in_strobe, writeStrobe, cycleStatusStrobe, phase1, phase2,
    output dataPeri, dataPeriOe, ready);
  modport host (output addr, dataHost, dataHostOe, readWrite, valid_address_qualifier,
    data_bus_drive_enable, data_in_strobe, writeStrobe, cycleStatusStrobe, phase1, phase2,
    input dataPeri, dataPeriOe, ready);
endinterface
`default_nettype wire

/* hdl/pbpp_peripheral.sv */
// Peripheral end: decodes address and control, holds one data word.
// Assumes bus signals synchronous to clk; phase1 is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Unselected peripheral floats data during reads
// - Processor reads: address, read strobe, sample
// - Processor writes: address, then strobe, data
// - Selected write captures word, replaces old
// - Unselected elements float during write cycles
// - Access valid only with qualifier; readWrite direction
// - Drive enable links processor data, phase two
// - Hold time by stretching drive enable
// - Sixteen address lines, eight data lines
// - Status bus same widths; data-in, write strobes
// - Status word opens every machine cycle
// - Latch status on phase one with strobe
// - Decode status into four cycle strobes
// - Ready low stretches cycle whole clocks
// - Shared space: address decode picks target
// - Separate-space processor marks memory or I/O
// - I/O may be mapped into memory space
module pbpp_peripheral import pbpp_pkg::*; #(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 16'hbf04,
  parameter bit MEM_MAPPED = 1'b0,
  parameter int WAIT_STATES = WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pbpp_style_t busStyle,
  pbpp_if.peri bus,
  input wire logic [DATA_W-1:0] readData,
  output logic [DATA_W-1:0] storedWord,
  output logic wordWritten,
  output logic [3:0] cycleStrobes
);
  // ==========================================================
  // Select and cycle decode
  logic [STAT_W-1:0] statusWord;
  logic addrHit;
  logic memRd, memWr, ioRd, ioWr;
  logic selRead, selWrite;
  logic writeQualPrev;
  logic [3:0] waitCnt;
  assign addrHit = (bus.addr == BASE_ADDR);
  assign memRd = statusWord[ST_MEMR] & bus.data_in_strobe;
  assign ioRd = statusWord[ST_INP] & bus.data_in_strobe;
  assign memWr = statusWord[ST_WO_N] == 1'b0 && !statusWord[ST_OUT] && bus.writeStrobe;
  assign ioWr = statusWord[ST_OUT] & bus.writeStrobe;
  assign cycleStrobes = {ioWr, ioRd, memWr, memRd};
  always_comb begin
    if (busStyle == PBPP_SHARED) begin
      selRead = addrHit && bus.valid_address_qualifier && bus.readWrite;
      selWrite = addrHit && bus.valid_address_qualifier && !bus.readWrite
        && bus.data_bus_drive_enable;
    end else begin
      selRead = addrHit && (MEM_MAPPED ? memRd : ioRd);
      selWrite = addrHit && (MEM_MAPPED ? memWr : ioWr);
    end
  end
  // ==========================================================
  // Status latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statusWord <= STAT_RST;
    end else if (bus.phase1 && bus.cycleStatusStrobe) begin
      statusWord <= bus.dataHost;
    end
  end
  // ==========================================================
  // Write capture on each clock of the qualified strobe; wordWritten pulses after its trailing edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      writeQualPrev <= 1'b0;
      storedWord <= DATA_RST;
      wordWritten <= 1'b0;
    end else begin
      writeQualPrev <= selWrite;
      wordWritten <= 1'b0;
      if (selWrite && bus.dataHostOe) begin
        storedWord <= bus.dataHost;
      end
      if (writeQualPrev && !selWrite) begin
        wordWritten <= 1'b1;
      end
    end
  end
  // ==========================================================
  // Read drive and wait states
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.dataPeri <= DATA_RST;
    end else begin
      bus.dataPeri <= readData;
    end
  end
  assign bus.dataPeriOe = selRead;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
    end else if (!(selRead || selWrite)) begin
      waitCnt <= 4'h0;
    end else if (waitCnt < 4'(WAIT_STATES)) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
  assign bus.ready = !((selRead || selWrite) && waitCnt < 4'(WAIT_STATES));
endmodule
`default_nettype wire

/* hdl/pbpp_processor.sv */
// Processor end: runs single read or write cycles on the bus.
// Assumes one request at a time; req is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module pbpp_processor import pbpp_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire pbpp_style_t busStyle,
  pbpp_if.host bus,
  input wire logic req,
  input wire logic reqWrite,
  input wire logic reqIo,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdData
);
  // ==========================================================
  // Phase divider
  logic [1:0] divCnt;
  pbpp_state_t state;
  logic isWrite;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCnt <= 2'h0;
    end else begin
      divCnt <= divCnt + 2'h1;
    end
  end
  assign bus.phase1 = (divCnt == 2'h0);
  assign bus.phase2 = (divCnt == 2'h2);
  assign bus.data_bus_drive_enable = bus.phase2 || state == PBPP_STRB;
  // ==========================================================
  // Cycle sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= PBPP_IDLE;
      isWrite <= 1'b0;
      bus.addr <= 16'h0000;
      bus.dataHost <= DATA_RST;
      bus.dataHostOe <= 1'b0;
      bus.readWrite <= 1'b1;
      bus.valid_address_qualifier <= 1'b0;
      bus.data_in_strobe <= 1'b0;
      bus.writeStrobe <= 1'b0;
      bus.cycleStatusStrobe <= 1'b0;
      rdData <= DATA_RST;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        PBPP_IDLE: begin
          if (req) begin
            isWrite <= reqWrite;
            bus.addr <= reqAddr;
            if (busStyle == PBPP_STATUS) begin
              bus.dataHost <= {!reqIo && !reqWrite, reqIo && !reqWrite, 1'b0, reqIo && reqWrite,
                3'h0, !reqWrite};
              bus.dataHostOe <= 1'b1;
              bus.cycleStatusStrobe <= 1'b1;
              state <= PBPP_STAT;
            end else begin
              bus.valid_address_qualifier <= 1'b1;
              bus.readWrite <= !reqWrite;
              state <= PBPP_ADDR;
            end
          end
        end
        PBPP_STAT: begin
          if (bus.phase1) begin
            bus.cycleStatusStrobe <= 1'b0;
            bus.dataHostOe <= 1'b0;
            state <= PBPP_ADDR;
          end
        end
        PBPP_ADDR: begin
          if (bus.phase2) begin
            bus.dataHost <= reqData;
            bus.dataHostOe <= isWrite;
            bus.writeStrobe <= isWrite && busStyle == PBPP_STATUS;
            bus.data_in_strobe <= !isWrite && busStyle == PBPP_STATUS;
            state <= PBPP_STRB;
          end
        end
        PBPP_STRB: begin
          if (bus.ready) begin
            state <= PBPP_DONE;
          end
        end
        PBPP_DONE: begin
          if (!isWrite) begin
            rdData <= bus.dataPeri;
          end
          bus.writeStrobe <= 1'b0;
          bus.data_in_strobe <= 1'b0;
          bus.valid_address_qualifier <= 1'b0;
          bus.readWrite <= 1'b1;
          bus.dataHostOe <= 1'b0;
          done <= 1'b1;
          state <= PBPP_IDLE;
        end
        default: begin
          state <= PBPP_IDLE;
        end
      endcase
    end
  end
  assign busy = (state != PBPP_IDLE);
endmodule
`default_nettype wire

/* tb/pbpp_sva.sv */
// Concurrent checks on the bus signals between the two port ends.
// Assumes tb_top instantiates it beside the interface, on one clock.
`timescale 1ns/1ns
`default_nettype none
module pbpp_sva import pbpp_pkg::*; #(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 16'hbf04
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dataHostOe,
  input wire logic dataPeriOe,
  input wire logic data_in_strobe,
  input wire logic writeStrobe,
  input wire logic cycleStatusStrobe,
  input wire logic phase1,
  input wire logic ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Data bus ownership
  sel_float_a: assert property (dataPeriOe |-> addr == BASE_ADDR)
    else $error("data driven while not addressed");
  one_driver_a: assert property (dataPeriOe |-> !dataHostOe)
    else $error("both ends drive data");
  // ==========================================================
  // Cycle timing
  read_addr_a: assert property (dataPeriOe && $past(dataPeriOe) |-> $stable(addr))
    else $error("address moved during read");
  write_addr_a: assert property ($rose(writeStrobe) |-> $stable(addr))
    else $error("address not set before write strobe");
  strobe_excl_a: assert property (writeStrobe |-> !data_in_strobe)
    else $error("read and write strobes together");
  status_latch_a: assert property ($rose(cycleStatusStrobe) |-> ##[0:4] phase1)
    else $error("status not latched by phase one");
  wait_len_a: assert property ($fell(ready) |=> !ready ##1 ready)
    else $error("wait stretch not two cycles");
  wait_hold_a: assert property (!ready |=> $stable(addr))
    else $error("address moved during wait");
  cover property ($rose(dataPeriOe));
  cover property ($rose(writeStrobe));
  cover property ($fell(ready));
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Bench joining processor end and peripheral end through the interface.
// Assumes the package and design modules are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb_top import pbpp_pkg::*;;
  typedef struct packed {
    logic style;
    logic wr;
    logic io;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] expStored;
    logic [5:0] expBus;
  } pbpp_row_t;
  logic clk, rst_n, req, reqWrite, reqIo, busy, done, wordWritten;
  logic [15:0] reqAddr;
  logic [7:0] reqData, readData, rdData, storedWord;
  logic [3:0] cycleStrobes;
  logic [5:0] seenBus;
  pbpp_style_t style;
  int failures = 0;
  int checksDone = 0;
  pbpp_row_t rows [8] = '{
    '{1'b0, 1'b1, 1'b0, 16'hbf04, 8'ha5, 8'ha5, 6'h20},
    '{1'b0, 1'b0, 1'b0, 16'hbf04, 8'hc3, 8'ha5, 6'h10},
    '{1'b0, 1'b1, 1'b0, 16'h1234, 8'hff, 8'ha5, 6'h00},
    '{1'b1, 1'b1, 1'b1, 16'hbf04, 8'h5a, 8'h5a, 6'h28},
    '{1'b1, 1'b0, 1'b1, 16'hbf04, 8'h96, 8'h5a, 6'h14},
    '{1'b1, 1'b1, 1'b0, 16'hbf04, 8'h77, 8'h5a, 6'h02},
    '{1'b1, 1'b0, 1'b0, 16'hbf04, 8'h3c, 8'h5a, 6'h01},
    '{1'b0, 1'b0, 1'b0, 16'h1234, 8'he7, 8'h5a, 6'h00}};
  pbpp_if pbpp_if_inst ();
  pbpp_peripheral pbpp_peripheral_inst (.clk(clk), .rst_n(rst_n), .busStyle(style),
    .bus(pbpp_if_inst.peri), .readData(readData), .storedWord(storedWord),
    .wordWritten(wordWritten), .cycleStrobes(cycleStrobes));
  pbpp_processor pbpp_processor_inst (.clk(clk), .rst_n(rst_n), .busStyle(style),
    .bus(pbpp_if_inst.host), .req(req), .reqWrite(reqWrite), .reqIo(reqIo), .reqAddr(reqAddr),
    .reqData(reqData), .busy(busy), .done(done), .rdData(rdData));
  pbpp_sva pbpp_sva_inst (.clk(clk), .rst_n(rst_n), .addr(pbpp_if_inst.addr),
    .dataHostOe(pbpp_if_inst.dataHostOe), .dataPeriOe(pbpp_if_inst.dataPeriOe),
    .data_in_strobe(pbpp_if_inst.data_in_strobe), .writeStrobe(pbpp_if_inst.writeStrobe),
    .cycleStatusStrobe(pbpp_if_inst.cycleStatusStrobe), .phase1(pbpp_if_inst.phase1),
    .ready(pbpp_if_inst.ready));
  // ==========================================================
  // Checking and closing
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // One processor cycle, req held for len clocks; seen gathers bus activity
  task automatic op(input pbpp_row_t r, input int len, output logic [5:0] seen);
    int n;
    seen = 6'h00;
    @(negedge clk);
    style = pbpp_style_t'(r.style);
    {reqWrite, reqIo, reqAddr, reqData} = {r.wr, r.io, r.addr, r.data};
    readData = r.data;
    req = 1'b1;
    repeat (len) @(negedge clk);
    req = 1'b0;
    for (n = 0; n < 200 && done !== 1'b1; n++) begin
      @(negedge clk);
      seen |= {wordWritten, pbpp_if_inst.dataPeriOe, cycleStrobes};
    end
    if (n == 200) check(8'h01, 8'h00);
    @(negedge clk);
    seen |= {wordWritten, pbpp_if_inst.dataPeriOe, cycleStrobes};
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  initial begin
    {rst_n, req, reqWrite, reqIo, reqAddr, reqData, readData} = '0;
    style = PBPP_SHARED;
    repeat (10) @(negedge clk);
    check(storedWord, DATA_RST);
    check({6'h00, pbpp_if_inst.ready, pbpp_if_inst.dataPeriOe}, 8'h02);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      op(rows[i], 1, seenBus);
      check(storedWord, rows[i].expStored);
      check({2'h0, seenBus}, {2'h0, rows[i].expBus});
      if (!rows[i].wr && rows[i].expBus[4]) check(rdData, rows[i].data);
    end
    // Second request while busy is ignored
    op('{1'b0, 1'b1, 1'b0, 16'hbf04, 8'h11, 8'h11, 6'h20}, 2, seenBus);
    check({2'h0, seenBus}, 8'h20);
    repeat (30) @(negedge clk);
    check(storedWord, 8'h11);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    check(storedWord, DATA_RST);
    complete_run;
  end
endmodule
`default_nettype wire
